// ==== rpl_pkg.sv ====
// constants, codes and types for the pre-divider and loop-2 block
// assumes one 100 MHz core clock and synchronous pins
//
// Contract
// - loop two powered down until bit cleared
// - three-bit mode code selects loop two mode
// - automatic mode follows selection events
// - free-run output from system clock only
// - locked output tracks selected reference
// - loop two bandwidth above 25 Hz
// - average off freezes last integral value
// - average on uses 1.5 mHz filtered value
// - output offset clamped to hard limit
// - per-input four-bit field picks sync pin
// - four-bit code selects loop target rate
// - fractional plus integer divider, high-rate on 0-3
// - high-rate divider divides by 4, 5, or passes
// - integer divider divides by factor plus one
// - fractional divider uses 16-bit numerator/denominator
// - qualified inputs offered to both loops
package rpl_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int NUM_REF   = 6;   // reference inputs
   localparam int NUM_HR    = 4;   // inputs with a high-rate divider
   localparam int FREQ_W    = 32;  // signed frequency offset word
   localparam int FACTOR_W  = 15;  // integer division factor
   localparam int FRAC_W    = 16;  // fractional numerator / denominator

   // ****************************************
   // loop-2 mode codes
   // ****************************************
   localparam logic [2:0] MODE_AUTO   = 3'h0;
   localparam logic [2:0] MODE_FREE   = 3'h1;
   localparam logic [2:0] MODE_HOLD   = 3'h2;
   localparam logic [2:0] MODE_LOCK   = 3'h4;

   // ****************************************
   // target rate codes
   // ****************************************
   localparam logic [3:0] RATE_C_8K   = 4'h0;
   localparam logic [3:0] RATE_C_T1E1 = 4'h1;
   localparam logic [3:0] RATE_C_6M48 = 4'h2;
   localparam logic [3:0] RATE_C_2K   = 4'h9;
   localparam logic [3:0] RATE_C_4K   = 4'hA;
   localparam logic [3:0] RATE_C_1PPS = 4'hB;
   localparam logic [3:0] RATE_C_6M25 = 4'hC;

   // ****************************************
   // high-rate divider select codes
   // ****************************************
   localparam logic [1:0] HR_PASS     = 2'h0;
   localparam logic [1:0] HR_DIV4     = 2'h1;
   localparam logic [1:0] HR_DIV5     = 2'h2;
   localparam logic [2:0] HR_LIM4     = 3'h3;  // last count of divide by 4
   localparam logic [2:0] HR_LIM5     = 3'h4;  // last count of divide by 5

   // ****************************************
   // reset values and holdover filter
   // ****************************************
   localparam logic       PD_RESET    = 1'b1;
   localparam int         LOOP2_BW_MIN_HZ = 25;
   localparam int         HO_AVG_SHIFT    = 23;    // with the tick gives about 1.5 mHz
   localparam logic [9:0] HO_AVG_TICK     = 10'h3E7; // 1000 cycles per filter update

   typedef enum logic [1:0] {L2_FREE, L2_LOCK, L2_HOLD} rpl_l2_state_t;
   typedef enum logic [3:0] {
      RT_8K, RT_1M544, RT_2M048, RT_6M48, RT_2K, RT_4K, RT_1PPS, RT_6M25, RT_NONE
   } rpl_rate_t;

endpackage

// ==== rpl_div_if.sv ====
// carrier between the top and one input's divider chain
// assumes the top drives set-up; the chain returns its pulse
`timescale 1ns/1ps
interface rpl_div_if;
   import rpl_pkg::*;
   logic                edge_p;     // one-cycle rising edge of the reference
   logic [1:0]          hr_sel;     // high-rate divider select
   logic                int_bypass; // integer divider bypassed
   logic [FACTOR_W-1:0] factor;     // committed integer factor
   logic [FRAC_W-1:0]   num;        // fractional numerator
   logic [FRAC_W-1:0]   den;        // fractional denominator
   logic                div_p;      // divided output pulse

   modport top (output edge_p, hr_sel, int_bypass, factor, num, den, input div_p);
   modport div (input edge_p, hr_sel, int_bypass, factor, num, den, output div_p);
endinterface

// ==== rpl_div_chain.sv ====
// one input's pre-divider chain
// assumes edge pulses are at most one per cycle
`timescale 1ns/1ps
module rpl_div_chain #(
   parameter bit HAS_HR = 1'b1  // high-rate stage present
) (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   rpl_div_if.div    dif
);
   import rpl_pkg::*;

   typedef struct packed {
      logic [2:0]        hr_cnt;  // high-rate count
      logic [FACTOR_W-1:0] int_cnt; // integer count
      logic [FRAC_W:0]   acc;     // fractional accumulator
      logic              out;     // registered pulse
   } rpl_div_st_t;

   rpl_div_st_t q, d;
   logic        hr_p;
   logic        int_p;
   logic        fr_p;
   logic [FRAC_W:0] sum;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      d     = q;
      hr_p  = 1'b0;
      int_p = 1'b0;
      fr_p  = 1'b0;
      sum   = '0;
      if (!HAS_HR || dif.hr_sel == HR_PASS) begin
         hr_p = dif.edge_p;
      end else if (dif.edge_p) begin
         if (q.hr_cnt == ((dif.hr_sel == HR_DIV5) ? HR_LIM5 : HR_LIM4)) begin
            d.hr_cnt = '0;
            hr_p     = 1'b1;
         end else begin
            d.hr_cnt = q.hr_cnt + 3'h1;
         end
      end
      if (dif.int_bypass) begin
         int_p = hr_p;
      end else if (hr_p) begin
         if (q.int_cnt >= dif.factor) begin
            d.int_cnt = '0;
            int_p     = 1'b1;
         end else begin
            d.int_cnt = q.int_cnt + 15'h0001;
         end
      end
      if (dif.num == '0 || dif.den == '0) begin
         fr_p = int_p;  // unprogrammed ratio passes through
      end else if (int_p) begin
         sum = q.acc + {1'b0, dif.den};
         if (sum >= {1'b0, dif.num}) begin
            d.acc = sum - {1'b0, dif.num};
            fr_p  = 1'b1;
         end else begin
            d.acc = sum;
         end
      end
      d.out = fr_p;
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dif.div_p = q.out;

endmodule

// ==== rpl_ref_predivider_top.sv ====
// reference path pre-dividers, sync pin selection and loop-2 mode control
// assumes monitors, selection logic and loop filter sit outside; all inputs are
// synchronous to core_clk_i
`timescale 1ns/1ps
module rpl_ref_predivider_top (
   input  wire logic                                   core_clk_i,
   input  wire logic                                   rst_i,
   // reference pins and monitor verdicts
   input  wire logic [rpl_pkg::NUM_REF-1:0]            ref_i,
   input  wire logic [rpl_pkg::NUM_REF-1:0]            ref_qual_i,
   // loop-2 control
   input  wire logic                                   loop2_power_down_i,
   input  wire logic [2:0]                             loop2_mode_sel_i,
   input  wire logic                                   loop2_holdover_average_en_i,
   input  wire logic                                   loop2_sel_valid_i,
   input  wire logic [2:0]                             loop2_sel_idx_i,
   input  wire logic signed [rpl_pkg::FREQ_W-1:0]      loop2_integral_i,
   input  wire logic [rpl_pkg::FREQ_W-2:0]             hard_limit_i,
   input  wire logic [3:0]                             loop2_target_rate_i,
   input  wire logic                                   rate_family_i,
   // per-input divider set-up
   input  wire logic [rpl_pkg::NUM_HR-1:0][1:0]        high_rate_div_sel_i,
   input  wire logic [rpl_pkg::NUM_REF-1:0]            direct_div_i,
   input  wire logic [rpl_pkg::NUM_REF-1:0]            low_rate_lock_i,
   input  wire logic [rpl_pkg::NUM_REF-1:0]            div_wr_lo_i,
   input  wire logic [rpl_pkg::NUM_REF-1:0]            div_wr_hi_i,
   input  wire logic [7:0]                             div_wdata_i,
   input  wire logic [rpl_pkg::NUM_REF-1:0][15:0]      frac_num_i,
   input  wire logic [rpl_pkg::NUM_REF-1:0][15:0]      frac_den_i,
   input  wire logic [rpl_pkg::NUM_REF-1:0][3:0]       sync_src_i,
   // results
   output logic                                        loop2_active_o,
   output rpl_pkg::rpl_l2_state_t                      loop2_state_o,
   output logic signed [rpl_pkg::FREQ_W-1:0]           loop2_freq_o,
   output logic                                        loop2_reacquire_o,
   output rpl_pkg::rpl_rate_t                          loop2_rate_o,
   output logic [rpl_pkg::NUM_REF-1:0]                 ref_offer_o,
   output logic [rpl_pkg::NUM_REF-1:0]                 ref_div_o,
   output logic [rpl_pkg::NUM_REF-1:0]                 sync_pulse_o,
   output logic [rpl_pkg::NUM_REF-1:0][14:0]           integer_div_factor_o
);
   import rpl_pkg::*;

   localparam int AVG_W = FREQ_W + HO_AVG_SHIFT; // filter keeps fraction bits

   // ****************************************
   // state of the block
   // ****************************************
   typedef struct packed {
      rpl_l2_state_t                  st;       // loop-2 state
      logic                           pd;       // power-down copy
      logic signed [FREQ_W-1:0]       freq;     // output offset
      logic signed [FREQ_W-1:0]       integ;    // last integral sample
      logic signed [FREQ_W-1:0]       ho;       // holdover value
      logic signed [AVG_W-1:0]        avg;      // averaged integral
      logic [9:0]                     tick;     // filter update timer
      logic                           reacq;    // reacquire pulse
      logic [2:0]                     idx;      // last selected input
      rpl_rate_t                      rate;     // decoded rate
      logic [NUM_REF-1:0]             offer;    // qualified inputs
      logic [NUM_REF-1:0]             ref_d;    // pin delay for edges
      logic [NUM_REF-1:0]             sync;     // sync pulses
      logic [NUM_REF-1:0]             divo;     // divided pulses
      logic [NUM_REF-1:0][7:0]        lo;       // staged low bytes
      logic [NUM_REF-1:0][FACTOR_W-1:0] fac;    // committed factors
   } rpl_top_st_t;

   rpl_top_st_t        q, d;
   logic [NUM_REF-1:0] edge_w;   // rising edges this cycle
   logic [NUM_REF-1:0] div_w;    // chain pulses
   logic               hold_now; // entering holdover this cycle

   // ****************************************
   // helpers
   // ****************************************
   // clamp to plus or minus the limit
   function automatic logic signed [FREQ_W-1:0] clamp(
      input logic signed [FREQ_W-1:0] v,
      input logic [FREQ_W-2:0]        lim
   );
      logic signed [FREQ_W-1:0] l;
      l = $signed({1'b0, lim});
      if (v > l) begin
         clamp = l;
      end else if (v < -l) begin
         clamp = -l;
      end else begin
         clamp = v;
      end
   endfunction

   // code 1..6 picks a pin
   function automatic logic pin_edge(
      input logic [3:0]         code,
      input logic [NUM_REF-1:0] e
   );
      pin_edge = 1'b0;
      if (code >= 4'h1 && code <= 4'h6) begin
         pin_edge = e[code[2:0] - 3'h1];
      end
   endfunction

   // rate code decode
   function automatic rpl_rate_t rate_of(
      input logic [3:0] code,
      input logic       fam
   );
      case (code)
         RATE_C_8K:   rate_of = RT_8K;
         RATE_C_T1E1: rate_of = fam ? RT_2M048 : RT_1M544;
         RATE_C_6M48: rate_of = RT_6M48;
         RATE_C_2K:   rate_of = RT_2K;
         RATE_C_4K:   rate_of = RT_4K;
         RATE_C_1PPS: rate_of = RT_1PPS;
         RATE_C_6M25: rate_of = RT_6M25;
         default:     rate_of = RT_NONE; // reserved codes
      endcase
   endfunction

   // ****************************************
   // divider chains
   // ****************************************
   assign edge_w = ref_i & ~q.ref_d;

   for (genvar i = 0; i < NUM_REF; i++) begin : g_ch
      rpl_div_if dif ();
      assign dif.edge_p = edge_w[i];
      assign dif.hr_sel = (i < NUM_HR) ? high_rate_div_sel_i[(i < NUM_HR) ? i : 0] : HR_PASS;
      // integer stage runs only when direct_div_i or low_rate_lock_i is set
      assign dif.int_bypass = ~(direct_div_i[i] | low_rate_lock_i[i]);
      assign dif.factor = q.fac[i];
      assign dif.num    = frac_num_i[i];
      assign dif.den    = frac_den_i[i];
      assign div_w[i]   = dif.div_p;
      rpl_div_chain #(
         .HAS_HR (i < NUM_HR)
      ) u_chain (
         .core_clk_i (core_clk_i),
         .rst_i      (rst_i),
         .dif        (dif)
      );
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      d          = q;
      hold_now   = 1'b0;
      d.reacq    = 1'b0;
      d.ref_d    = ref_i;
      d.divo     = div_w;
      d.offer    = ref_qual_i;
      d.rate     = rate_of(loop2_target_rate_i, rate_family_i);
      d.integ    = loop2_integral_i;

      for (int i = 0; i < NUM_REF; i++) begin
         d.sync[i] = pin_edge(sync_src_i[i], edge_w);
      end

      // factor staging per input
      for (int i = 0; i < NUM_REF; i++) begin
         if (div_wr_lo_i[i]) begin
            d.lo[i] = div_wdata_i;
         end
         if (div_wr_hi_i[i]) begin
            d.fac[i] = {div_wdata_i[6:0], div_wr_lo_i[i] ? div_wdata_i : q.lo[i]};
         end
      end

      d.pd = loop2_power_down_i;
      if (q.pd) begin
         d.st   = L2_FREE;
         d.freq = '0;
      end else begin
         case (loop2_mode_sel_i)
            MODE_FREE: begin
               d.st = L2_FREE;
            end
            MODE_HOLD: begin
               if (q.st != L2_HOLD) begin
                  hold_now = 1'b1;
               end
               d.st = L2_HOLD;
            end
            MODE_LOCK: begin
               d.st = L2_LOCK;
            end
            // auto and reserved codes
            default: begin
               case (q.st)
                  L2_FREE, L2_HOLD: begin
                     if (loop2_sel_valid_i) begin
                        d.st = L2_LOCK;
                     end
                  end
                  L2_LOCK: begin
                     if (!loop2_sel_valid_i) begin
                        d.st     = L2_HOLD;
                        hold_now = 1'b1;
                     end else if (loop2_sel_idx_i != q.idx) begin
                        d.reacq = 1'b1;
                     end
                  end
                  default: begin
                     d.st = L2_FREE;
                  end
               endcase
            end
         endcase

         if (hold_now) begin
            d.ho = loop2_holdover_average_en_i ? q.avg[AVG_W-1 -: FREQ_W] : q.integ;
         end

         case (d.st)
            L2_FREE: d.freq = '0;
            L2_LOCK: d.freq = clamp(loop2_integral_i, hard_limit_i);
            L2_HOLD: d.freq = clamp(d.ho, hard_limit_i);
            default: d.freq = '0;
         endcase
      end

      if (loop2_sel_valid_i) begin
         d.idx = loop2_sel_idx_i;
      end

      d.tick = (q.tick == HO_AVG_TICK) ? 10'h000 : q.tick + 10'h001;
      if (q.st == L2_LOCK && q.tick == HO_AVG_TICK) begin
         d.avg = q.avg + (($signed({loop2_integral_i, {HO_AVG_SHIFT{1'b0}}}) - q.avg)
                 >>> HO_AVG_SHIFT);
      end
   end

   // ****************************************
   // state register
   // ****************************************
   // loop two wide bandwidth
   // bandwidth lives in the loop filter outside
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q    <= '0;
         q.pd <= PD_RESET;
         q.st <= L2_FREE;
         q.rate <= RT_8K;
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // outputs, all from flops
   // ****************************************
   assign loop2_active_o       = ~q.pd;
   assign loop2_state_o        = q.st;
   assign loop2_freq_o         = q.freq;
   assign loop2_reacquire_o    = q.reacq;
   assign loop2_rate_o         = q.rate;
   assign ref_offer_o          = q.offer;
   assign ref_div_o            = q.divo;
   assign sync_pulse_o         = q.sync;
   assign integer_div_factor_o = q.fac;

endmodule

// ==== rpl_ref_predivider_props.sv ====
// checker for loop-2 mode, factor writes and sync
// assumes it is bound to rpl_ref_predivider_top and sees its ports only
`timescale 1ns/1ps
module rpl_ref_predivider_props (
   input wire logic                                  core_clk_i,
   input wire logic                                  rst_i,
   input wire logic [rpl_pkg::NUM_REF-1:0]           ref_i,
   input wire logic                                  loop2_power_down_i,
   input wire logic [2:0]                            loop2_mode_sel_i,
   input wire logic                                  loop2_sel_valid_i,
   input wire logic signed [rpl_pkg::FREQ_W-1:0]     loop2_integral_i,
   input wire logic [rpl_pkg::FREQ_W-2:0]            hard_limit_i,
   input wire logic [rpl_pkg::NUM_REF-1:0]           div_wr_lo_i,
   input wire logic [rpl_pkg::NUM_REF-1:0]           div_wr_hi_i,
   input wire logic [7:0]                            div_wdata_i,
   input wire logic [rpl_pkg::NUM_REF-1:0][3:0]      sync_src_i,
   input wire logic                                  loop2_active_o,
   input wire rpl_pkg::rpl_l2_state_t                loop2_state_o,
   input wire logic signed [rpl_pkg::FREQ_W-1:0]     loop2_freq_o,
   input wire logic [rpl_pkg::NUM_REF-1:0]           sync_pulse_o,
   input wire logic [rpl_pkg::NUM_REF-1:0][14:0]     integer_div_factor_o
);
   import rpl_pkg::*;
   // ****************************************
   // clocking and helpers
   // ****************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic signed [FREQ_W-1:0] lim_s;   // limit as a signed word
   logic                     run_w;   // loop two enabled
   assign lim_s = $signed({1'b0, hard_limit_i});
   assign run_w = !loop2_power_down_i && loop2_active_o;
   // ****************************************
   // mode control
   // ****************************************
   a_pd_free:
      assert property (!loop2_active_o |=> loop2_state_o == L2_FREE && loop2_freq_o == '0)
      else $error("not idle in power down");
   a_free_zero:
      assert property (loop2_state_o == L2_FREE |-> loop2_freq_o == '0)
      else $error("free-run offset not zero");
   a_forced_hold:
      assert property (run_w && loop2_mode_sel_i == MODE_HOLD |=> loop2_state_o == L2_HOLD)
      else $error("forced holdover not entered");
   a_forced_lock:
      assert property (run_w && loop2_mode_sel_i == MODE_LOCK |=> loop2_state_o == L2_LOCK)
      else $error("forced locked not entered");
   a_auto_select:
      assert property (run_w && loop2_mode_sel_i == MODE_AUTO && loop2_sel_valid_i
                       |=> loop2_state_o == L2_LOCK)
      else $error("selection did not lock");
   a_auto_loss:
      assert property (run_w && loop2_mode_sel_i == MODE_AUTO && !loop2_sel_valid_i
                       && loop2_state_o == L2_LOCK |=> loop2_state_o == L2_HOLD)
      else $error("loss did not hold");
   // ****************************************
   // output offset
   // ****************************************
   a_freq_clamp:
      assert property ($stable(hard_limit_i) && loop2_state_o == L2_LOCK
                       |-> loop2_freq_o <= lim_s && -loop2_freq_o <= lim_s)
      else $error("offset beyond hard limit");
   a_lock_track:
      assert property (run_w && loop2_mode_sel_i == MODE_LOCK && loop2_integral_i <= lim_s
                       && -loop2_integral_i <= lim_s |=> loop2_freq_o == $past(loop2_integral_i))
      else $error("locked offset not tracking");
   a_hold_frozen:
      assert property (run_w && loop2_mode_sel_i == MODE_HOLD && loop2_state_o == L2_HOLD
                       |=> $stable(loop2_freq_o))
      else $error("holdover offset moved");
   // ****************************************
   // sync and factor writes
   // ****************************************
   a_sync_edge:
      assert property ($rose(ref_i[0]) && sync_src_i[4] == 4'h1 |=> sync_pulse_o[4])
      else $error("sync pulse missing");
   a_lo_staged:
      assert property (div_wr_lo_i[0] && !div_wr_hi_i[0] |=> $stable(integer_div_factor_o[0]))
      else $error("low byte moved factor");
   a_hi_commit:
      assert property (div_wr_hi_i[0] && !div_wr_lo_i[0] && $past(div_wr_lo_i[0], 2)
         |=> integer_div_factor_o[0] == {$past(div_wdata_i[6:0]), $past(div_wdata_i, 3)})
      else $error("factor not committed whole");
endmodule

bind rpl_ref_predivider_top rpl_ref_predivider_props u_rpl_ref_predivider_props (
   .core_clk_i, .rst_i, .ref_i, .loop2_power_down_i, .loop2_mode_sel_i, .loop2_sel_valid_i,
   .loop2_integral_i, .hard_limit_i, .div_wr_lo_i, .div_wr_hi_i, .div_wdata_i, .sync_src_i,
   .loop2_active_o, .loop2_state_o, .loop2_freq_o, .sync_pulse_o, .integer_div_factor_o
);

// ==== rpl_ref_source.sv ====
// reference and sync pulse source model
// assumes one core clock; pins stand low while not enabled
`timescale 1ns/1ps
module rpl_ref_source (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic [5:0]  en_i,     // pins that carry a clock
   input  wire logic [7:0]  half_i,   // half period in core cycles
   output logic      [5:0]  ref_o,
   output logic      [15:0] edges_o   // rising edges sent
);
   logic [7:0] cnt_q;   // half-period counter
   logic       lvl_q;   // common level of all pins
   // steady pulse rate set by the bench
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i || en_i == '0) begin
         cnt_q <= '0;
         lvl_q <= 1'b0;
         edges_o <= '0;
      end else if (cnt_q == half_i - 8'h01) begin
         cnt_q <= '0;
         lvl_q <= !lvl_q;
         edges_o <= edges_o + {15'h0, !lvl_q};
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   assign ref_o = en_i & {6{lvl_q}};
endmodule

// ==== rpl_ref_predivider_bench.sv ====
// bench for pre-dividers and loop-2 mode
// assumes a bound checker and the source model
`timescale 1ns/1ps
module rpl_ref_predivider_bench;
   import rpl_pkg::*;
   typedef struct {
      logic pd; logic [2:0] md; logic sv; int ig; logic [3:0] rc; logic fm;
      rpl_l2_state_t st; int fq; rpl_rate_t rt;
   } rpl_row_t;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic loop2_power_down_i = 1'b1;
   logic [2:0] loop2_mode_sel_i = '0;
   logic loop2_holdover_average_en_i = 1'b0, loop2_sel_valid_i = 1'b0, rate_family_i = 1'b0;
   logic [2:0] loop2_sel_idx_i = '0;
   logic signed [31:0] loop2_integral_i = '0, loop2_freq_o;
   logic [30:0] hard_limit_i = 31'h3E8;
   logic [3:0] loop2_target_rate_i = '0;
   logic [3:0][1:0] high_rate_div_sel_i = '0;
   logic [5:0] ref_i, ref_qual_i = '0, direct_div_i = '0, low_rate_lock_i = '0;
   logic [5:0] div_wr_lo_i = '0, div_wr_hi_i = '0, src_en = '0;
   logic [7:0] div_wdata_i = '0;
   logic [5:0][15:0] frac_num_i = '0, frac_den_i = '0;
   logic [5:0][3:0] sync_src_i = '0;
   logic loop2_active_o, loop2_reacquire_o;
   rpl_l2_state_t loop2_state_o;
   rpl_rate_t loop2_rate_o;
   logic [5:0] ref_offer_o, ref_div_o, sync_pulse_o;
   logic [5:0][14:0] integer_div_factor_o;
   logic [15:0] edges;
   int miscompares = 0, tests_run = 0;
   int ndiv [6] = '{default: 0}, nsync [6] = '{default: 0};
   int exp_div [6] = '{20, 15, 12, 30, 60, 30};
   // control cases
   rpl_row_t rows [13] = '{
      '{1, MODE_AUTO, 1, 100, RATE_C_8K, 0, L2_FREE, 0, RT_8K},
      '{0, MODE_AUTO, 1, 100, RATE_C_T1E1, 0, L2_LOCK, 100, RT_1M544},
      '{0, MODE_AUTO, 1, 5000, RATE_C_T1E1, 1, L2_LOCK, 1000, RT_2M048},
      '{0, MODE_AUTO, 1, -700, RATE_C_6M48, 0, L2_LOCK, -700, RT_6M48},
      '{0, MODE_AUTO, 0, -700, RATE_C_2K, 0, L2_HOLD, -700, RT_2K},
      '{0, MODE_AUTO, 0, 300, RATE_C_4K, 0, L2_HOLD, -700, RT_4K},
      '{0, MODE_AUTO, 1, 300, RATE_C_1PPS, 0, L2_LOCK, 300, RT_1PPS},
      '{0, MODE_FREE, 1, 300, RATE_C_6M25, 0, L2_FREE, 0, RT_6M25},
      '{0, MODE_LOCK, 0, 50, 4'h3, 0, L2_LOCK, 50, RT_NONE},
      '{0, MODE_HOLD, 0, 60, 4'hD, 0, L2_HOLD, 50, RT_NONE},
      '{0, 3'h7, 0, 60, 4'hF, 0, L2_HOLD, 50, RT_NONE},
      '{0, MODE_AUTO, 1, -5000, RATE_C_8K, 0, L2_LOCK, -1000, RT_8K},
      '{1, MODE_LOCK, 1, 60, RATE_C_8K, 0, L2_FREE, 0, RT_8K}};
   // ****************************************
   // clock, design and source model
   // ****************************************
   always #5 core_clk_i = !core_clk_i;
   rpl_ref_predivider_top u_rpl_ref_predivider_top (
      .core_clk_i, .rst_i, .ref_i, .ref_qual_i, .loop2_power_down_i, .loop2_mode_sel_i,
      .loop2_holdover_average_en_i, .loop2_sel_valid_i, .loop2_sel_idx_i, .loop2_integral_i,
      .hard_limit_i, .loop2_target_rate_i, .rate_family_i, .high_rate_div_sel_i,
      .direct_div_i, .low_rate_lock_i, .div_wr_lo_i, .div_wr_hi_i, .div_wdata_i, .frac_num_i,
      .frac_den_i, .sync_src_i, .loop2_active_o, .loop2_state_o, .loop2_freq_o,
      .loop2_reacquire_o, .loop2_rate_o, .ref_offer_o, .ref_div_o, .sync_pulse_o,
      .integer_div_factor_o);
   rpl_ref_source u_rpl_ref_source (.core_clk_i, .rst_i, .en_i(src_en), .half_i(8'h03),
      .ref_o(ref_i), .edges_o(edges));
   // pulse counters
   always @(posedge core_clk_i) begin
      for (int i = 0; i < 6; i++) begin
         ndiv[i] += int'(ref_div_o[i]);
         nsync[i] += int'(sync_pulse_o[i]);
      end
   end
   // ****************************************
   // checking and closing
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
         miscompares++;
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // one write strobe
   task automatic wr(input int n, input logic lo, input logic hi, input logic [7:0] d);
      @(posedge core_clk_i);
      div_wr_lo_i[n] <= lo;
      div_wr_hi_i[n] <= hi;
      div_wdata_i <= d;
      @(posedge core_clk_i);
      div_wr_lo_i[n] <= 1'b0;
      div_wr_hi_i[n] <= 1'b0;
   endtask
   // watchdog
   initial begin
      #200000;
      miscompares++;
      tally_and_finish;
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      #1;
      chk("active", loop2_active_o, 0);
      chk("state", loop2_state_o, L2_FREE);
      chk("factor", integer_div_factor_o[0], 0);
      foreach (rows[i]) begin
         @(posedge core_clk_i);
         loop2_power_down_i <= rows[i].pd;
         loop2_mode_sel_i <= rows[i].md;
         loop2_sel_valid_i <= rows[i].sv;
         loop2_integral_i <= rows[i].ig;
         loop2_target_rate_i <= rows[i].rc;
         rate_family_i <= rows[i].fm;
         repeat (2) @(posedge core_clk_i);
         #1;
         chk("active", loop2_active_o, !rows[i].pd);
         chk("state", loop2_state_o, rows[i].st);
         chk("freq", loop2_freq_o, rows[i].fq);
         chk("rate", loop2_rate_o, rows[i].rt);
      end
      // low byte only stages
      wr(0, 1'b1, 1'b0, 8'hAA);
      #1;
      chk("staged", integer_div_factor_o[0], 0);
      wr(0, 1'b0, 1'b1, 8'h7F);
      #1;
      chk("commit", integer_div_factor_o[0], 15'h7FAA);
      wr(0, 1'b1, 1'b0, 8'h02);
      wr(0, 1'b0, 1'b1, 8'h00);
      wr(3, 1'b1, 1'b0, 8'h01);
      wr(3, 1'b0, 1'b1, 8'h00);
      #1;
      chk("factor3", integer_div_factor_o[3], 1);
      // divider set-up: in0 /3, in1 /4, in2 /5, in3 /2, in4 pass, in5 frac 2/1
      high_rate_div_sel_i <= {HR_PASS, HR_DIV5, HR_DIV4, HR_PASS};
      direct_div_i <= 6'h01;
      low_rate_lock_i <= 6'h08;
      frac_num_i[5] <= 16'h0002;
      frac_den_i[5] <= 16'h0001;
      // in4 fully bypassed, synced to pin 0
      sync_src_i[4] <= 4'h1;
      ref_qual_i <= 6'h2D;
      @(posedge core_clk_i);
      #1;
      chk("offer", ref_offer_o, 6'h2D);
      src_en <= 6'h3F;
      for (int k = 0; k < 2000 && edges != 16'd60; k++) @(posedge core_clk_i);
      src_en <= '0;
      repeat (4) @(posedge core_clk_i);
      #1;
      foreach (ndiv[i]) chk("div", ndiv[i], exp_div[i]);
      chk("sync4", nsync[4], 60);
      chk("sync0", nsync[0], 0);
      tally_and_finish;
   end
endmodule
